/* File: core/sah_device.sv */
// converter end: serial control, conversion timer, result output
// assumes link pins are asynchronous to hclk; analog result is an input
// What this block does
// - bits 3:2 pick 8, 12 or 16 bits
// - new length governs its own frame
// - twelve clocks, convert after twelfth fall
// - sixteen clocks, four zero pad bits
// - eight clocks, upper eight result bits only
// - length takes effect after six rises
// - bit 1 shift order, next cycle
// - bit 0 signed coding, next conversion
// - unsigned code passes straight through
// - signed equals unsigned with inverted top bit
// - command picks input, loads config unless reserved
// - end flag high, low after last fall
// - end flag rises on the latch edge, resets interface
// - first bit at end rise or select fall
// - select high floats output, then clock ignored
// - select high resets after debounce
// - host keeps select low normally
// - capture eight input bits msb first
// - next bit on each later falling edge
// - conversion time from internal oscillator
// - output low during conversion
//
// The implementer's own choices: register access over AHB-Lite and the address map.
module sah_device
   import sah_pkg::*;
(
   // system
   input wire logic hclk,
   input wire logic hresetn,
   // link
   sah_link_if.device link,
   // analog side
   input wire logic [11:0] sample_code,
   output logic [3:0] channel_sel,
   output logic sample_hold
);
   typedef enum logic [1:0] {sah_idle, sah_io, sah_conv} sah_dev_state_t;
   sah_dev_state_t state;
   logic [1:0] cs_s, ck_s, di_s;
   logic ck_d, cs_d;
   logic cs_ok;
   logic [7:0] deb;
   logic [4:0] rises, falls;
   logic [7:0] in_sr;
   logic [3:0] cfg;
   logic [3:0] cmd;
   logic [1:0] len_sel;
   logic lsb_first, lsb_next, signed_next;
   logic [15:0] result;
   logic [15:0] out_sr;
   logic [15:0] conv_cnt;
   logic rise, fall, cs_n;
   logic [4:0] flen;
   logic [11:0] coded;
   assign cs_n = cs_s[1];
   assign rise = cs_ok && ck_s[1] && !ck_d;
   assign fall = cs_ok && !ck_s[1] && ck_d;
   assign flen = sah_frame_len(len_sel);
   assign coded = signed_next ? (sample_code ^ sah_mid_code) : sample_code;
   assign lsb_next = cfg[sah_lsb_bit];
   assign signed_next = cfg[sah_sign_bit];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cs_s <= 2'h3;
         ck_s <= 2'h0;
         di_s <= 2'h0;
         ck_d <= 1'b0;
         cs_d <= 1'b1;
      end else begin
         cs_s <= {cs_s[0], link.cs_n};
         ck_s <= {ck_s[0], link.sclk};
         di_s <= {di_s[0], link.serial_input_byte};
         ck_d <= ck_s[1];
         cs_d <= cs_n;
      end
   end

   // debounce on select, both directions
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         deb <= 8'h00;
         cs_ok <= 1'b0;
      end else if (cs_n != cs_d) begin
         deb <= 8'h00;
         if (cs_n) cs_ok <= cs_ok;
      end else if (deb < 8'(sah_debounce_cyc)) begin
         deb <= deb + 8'h01;
      end else begin
         cs_ok <= !cs_n;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= sah_idle;
         rises <= 5'h00;
         falls <= 5'h00;
         in_sr <= 8'h00;
         cfg <= sah_cfg_reset;
         cmd <= 4'h0;
         len_sel <= 2'h0;
         lsb_first <= 1'b0;
         conv_cnt <= 16'h0000;
         result <= 16'h0000;
         sample_hold <= 1'b0;
      end else if (!cs_ok) begin
         if (state != sah_conv) begin
            state <= sah_idle;
            rises <= 5'h00;
            falls <= 5'h00;
         end
         if (state == sah_conv) begin
            conv_cnt <= conv_cnt + 16'h0001;
            if (conv_cnt >= 16'(sah_conv_cyc)) begin
               state <= sah_idle;
               lsb_first <= lsb_next;
               result <= {coded, 4'h0};
            end
         end
      end else begin
         unique case (state)
            sah_idle, sah_io: begin
               if (rise) begin
                  state <= sah_io;
                  rises <= rises + 5'h01;
                  if (rises < sah_in_bits) begin
                     in_sr <= {in_sr[6:0], di_s[1]};
                  end
                  // length bits arrive on rise 5 and 6
                  if (rises + 5'h01 == sah_len_edge) begin
                     len_sel <= {in_sr[0], di_s[1]};
                  end
               end
               if (fall) begin
                  falls <= falls + 5'h01;
                  if (falls + 5'h01 == sah_sample_edge) begin
                     sample_hold <= 1'b1;
                  end
                  if (falls + 5'h01 == flen) begin
                     state <= sah_conv;
                     sample_hold <= 1'b0;
                     conv_cnt <= 16'h0000;
                     cmd <= in_sr[7:4];
                     if (in_sr[7:4] != sah_cmd_reserved) begin
                        cfg <= in_sr[3:0];
                     end
                  end
               end
            end
            sah_conv: begin
               conv_cnt <= conv_cnt + 16'h0001;
               if (conv_cnt >= 16'(sah_conv_cyc)) begin
                  state <= sah_idle;
                  rises <= 5'h00;
                  falls <= 5'h00;
                  lsb_first <= lsb_next;
                  result <= {coded, 4'h0};
               end
            end
         endcase
      end
   end

   assign channel_sel = cmd;

   // output shifter
   logic start_out, conv_done, lsb_load;
   logic [15:0] load_res;
   assign conv_done = state == sah_conv && conv_cnt >= 16'(sah_conv_cyc);
   // result and order are latched on this same edge, so load them directly
   assign load_res = conv_done ? {coded, 4'h0} : result;
   assign lsb_load = conv_done ? lsb_next : lsb_first;
   assign start_out = conv_done || (!cs_n && cs_d);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_sr <= 16'h0000;
         link.sdo <= 1'b0;
         link.sdo_oe <= 1'b0;
         link.eoc <= 1'b1;
      end else begin
         link.sdo_oe <= !cs_n;
         link.eoc <= !(state == sah_conv) ||
                     (conv_cnt >= 16'(sah_conv_cyc));
         if (state == sah_conv && conv_cnt < 16'(sah_conv_cyc)) begin
            link.sdo <= 1'b0;
         end else if (start_out) begin
            if (lsb_load) begin
               out_sr <= 16'(load_res >> 1);
               link.sdo <= (flen == sah_len16) ? 1'b0 :
                           (flen == sah_len8) ? load_res[8] : load_res[4];
               if (flen == sah_len12) out_sr <= 16'(load_res >> 5);
               if (flen == sah_len8) out_sr <= 16'(load_res >> 9);
            end else begin
               out_sr <= {load_res[14:0], 1'b0};
               link.sdo <= load_res[15];
            end
         end else if (fall) begin
            if (lsb_first) begin
               link.sdo <= out_sr[0];
               out_sr <= {1'b0, out_sr[15:1]};
            end else begin
               link.sdo <= out_sr[15];
               out_sr <= {out_sr[14:0], 1'b0};
            end
         end
      end
   end
endmodule : sah_device

/* File: common/sah_pkg.sv */
// shared constants and types for the serial converter link
// assumes both ends run on one 200 MHz system clock
package sah_pkg;
   localparam int unsigned sah_clk_mhz = 200;
   // debounce, oscillator period and start delay in ns
   localparam int unsigned sah_debounce_ns = 100;
   localparam int unsigned sah_debounce_cyc =
      (sah_debounce_ns * sah_clk_mhz + 999) / 1000;
   localparam int unsigned sah_osc_ns = 40;
   localparam int unsigned sah_osc_start_ns = 25;
   // 13.5 oscillator periods, kept as 27 half periods
   localparam int unsigned sah_conv_half_periods = 27;
   localparam int unsigned sah_conv_ns =
      sah_osc_start_ns + (sah_conv_half_periods * sah_osc_ns) / 2;
   localparam int unsigned sah_conv_cyc =
      (sah_conv_ns * sah_clk_mhz + 999) / 1000;
   localparam int unsigned sah_idle_ns = 100;
   localparam int unsigned sah_idle_cyc =
      (sah_idle_ns * sah_clk_mhz + 999) / 1000;
   localparam int unsigned sah_half_div = 4;
   localparam logic [4:0] sah_len8 = 5'h08;
   localparam logic [4:0] sah_len12 = 5'h0C;
   localparam logic [4:0] sah_len16 = 5'h10;
   localparam logic [4:0] sah_in_bits = 5'h08;
   localparam logic [4:0] sah_sample_edge = 5'h04;
   localparam logic [4:0] sah_len_edge = 5'h06;
   localparam logic [3:0] sah_cmd_reserved = 4'hF;
   localparam logic [1:0] sah_fmt_8 = 2'h1;
   localparam logic [1:0] sah_fmt_16 = 2'h3;
   localparam int unsigned sah_len_hi = 3;
   localparam int unsigned sah_len_lo = 2;
   localparam int unsigned sah_lsb_bit = 1;
   localparam int unsigned sah_sign_bit = 0;
   localparam logic [3:0] sah_cfg_reset = 4'h0;
   localparam logic [11:0] sah_mid_code = 12'h800;
   // host register map
   localparam logic [31:0] sah_reg_cmd = 32'h0000_0000;
   localparam logic [31:0] sah_reg_stat = 32'h0000_0004;
   localparam logic [31:0] sah_reg_res = 32'h0000_0008;
   localparam logic [31:0] sah_reg_cs = 32'h0000_000C;
   localparam logic [1:0] sah_htrans_nonseq = 2'h2;
   function automatic logic [4:0] sah_frame_len(input logic [1:0] f);
      if (f == sah_fmt_8) return sah_len8;
      if (f == sah_fmt_16) return sah_len16;
      return sah_len12;
   endfunction : sah_frame_len
endpackage : sah_pkg

/* File: common/sah_link_if.sv */
// serial pins between host and converter
// assumes one system clock shared by the bench
interface sah_link_if;
   logic cs_n;
   logic sclk;
   logic serial_input_byte;
   logic sdo;
   logic sdo_oe;
   logic eoc;
   modport host (output cs_n, output sclk, output serial_input_byte,
                 input sdo, input sdo_oe, input eoc);
   modport device (input cs_n, input sclk, input serial_input_byte,
                   output sdo, output sdo_oe, output eoc);
endinterface : sah_link_if

/* File: core/sah_host.sv */
// host end: ahb-lite slave registers driving the serial master
// assumes one ahb master; link inputs are asynchronous to hclk
module sah_host
   import sah_pkg::*;
(
   // system
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // link
   sah_link_if.host link
);
   typedef enum logic [1:0] {sah_h_idle, sah_h_wait, sah_h_shift}
      sah_host_state_t;
   sah_host_state_t state;
   logic wr_pend;
   logic [31:0] a_addr;
   logic [1:0] eoc_s, do_s;
   logic [7:0] cmd_byte, tx_sr;
   logic [15:0] rx;
   logic [15:0] last_res;
   logic [4:0] bits, flen;
   logic [7:0] div, idle;
   logic go, busy, cs_req;
   assign hresp = 1'b0;
   assign flen = sah_frame_len(cmd_byte[sah_len_hi:sah_len_lo]);
   assign busy = state != sah_h_idle;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         eoc_s <= 2'h0;
         do_s <= 2'h0;
      end else begin
         eoc_s <= {eoc_s[0], link.eoc};
         do_s <= {do_s[0], link.sdo};
      end
   end

   // bus slave, zero wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         a_addr <= 32'h0000_0000;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         cmd_byte <= 8'h00;
         cs_req <= 1'b0;
         go <= 1'b0;
      end else begin
         go <= 1'b0;
         wr_pend <= hsel && htrans == sah_htrans_nonseq && hwrite;
         a_addr <= haddr;
         if (wr_pend && a_addr == sah_reg_cmd && !busy) begin
            cmd_byte <= hwdata[7:0];
            go <= 1'b1;
         end
         if (wr_pend && a_addr == sah_reg_cs) begin
            cs_req <= hwdata[0];
         end
         if (hsel && htrans == sah_htrans_nonseq && !hwrite) begin
            unique case (haddr)
               sah_reg_cmd: hrdata <= {24'h000000, cmd_byte};
               sah_reg_stat: hrdata <= {29'h0, eoc_s[1], cs_req, busy};
               sah_reg_res: hrdata <= {16'h0000, last_res};
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // serial master; sclk idles low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= sah_h_idle;
         link.cs_n <= 1'b1;
         link.sclk <= 1'b0;
         link.serial_input_byte <= 1'b0;
         tx_sr <= 8'h00;
         rx <= 16'h0000;
         last_res <= 16'h0000;
         bits <= 5'h00;
         div <= 8'h00;
         idle <= 8'h00;
      end else begin
         link.cs_n <= cs_req;
         unique case (state)
            sah_h_idle: begin
               if (go) begin
                  state <= sah_h_wait;
                  idle <= 8'h00;
                  tx_sr <= cmd_byte;
               end
            end
            sah_h_wait: begin
               // hold sclk low after select settles, then wait for eoc
               if (idle < 8'(sah_idle_cyc + sah_debounce_cyc)) begin
                  idle <= idle + 8'h01;
               end else if (eoc_s[1]) begin
                  state <= sah_h_shift;
                  bits <= 5'h00;
                  div <= 8'h00;
                  link.serial_input_byte <= tx_sr[7];
               end
            end
            sah_h_shift: begin
               div <= div + 8'h01;
               if (div == 8'(sah_half_div - 1)) begin
                  div <= 8'h00;
                  if (!link.sclk) begin
                     link.sclk <= 1'b1;
                  end else begin
                     // sample before the fall: sync delay exceeds half a clock
                     link.sclk <= 1'b0;
                     rx <= {rx[14:0], do_s[1]};
                     bits <= bits + 5'h01;
                     tx_sr <= {tx_sr[6:0], 1'b0};
                     link.serial_input_byte <= tx_sr[6];
                     if (bits + 5'h01 == flen) begin
                        state <= sah_h_idle;
                        last_res <= {rx[14:0], do_s[1]};
                     end
                  end
               end
            end
            default: state <= sah_h_idle;
         endcase
      end
   end
endmodule : sah_host

/* File: tb/sah_sva.sv */
// assertions on the serial link between host and converter ends
// assumes the testbench wires it beside the link interface
module sah_sva (
   // system
   input wire logic hclk,
   input wire logic hresetn,
   // link
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic serial_input_byte,
   input wire logic sdo,
   input wire logic sdo_oe,
   input wire logic eoc
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [4:0] n_rise;
   logic [7:0] low_cnt;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // rising shift clocks in the current frame
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) n_rise <= 5'h00;
      else if (!eoc) n_rise <= 5'h00;
      else if ($rose(sclk)) n_rise <= n_rise + 5'h01;
   end

   // cycles spent converting
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) low_cnt <= 8'h00;
      else if (eoc) low_cnt <= 8'h00;
      else low_cnt <= low_cnt + 8'h01;
   end

   property p_eoc_reset;
      $rose(hresetn) |-> eoc && !sdo_oe && cs_n && !sclk;
   endproperty
   a_eoc_reset: assert property (p_eoc_reset)
      else $error("end flag or pins wrong after reset");

   property p_frame_len;
      $fell(eoc) |->
         (n_rise == 5'h08 || n_rise == 5'h0C || n_rise == 5'h10) && !sclk;
   endproperty
   a_frame_len: assert property (p_frame_len)
      else $error("conversion started after wrong clock count");

   property p_conv_time;
      $rose(eoc) |-> low_cnt >= 8'h64 && low_cnt <= 8'h82;
   endproperty
   a_conv_time: assert property (p_conv_time)
      else $error("conversion time out of range");

   property p_sdo_low;
      !eoc && $past(eoc) == 1'b0 && sdo_oe |-> !sdo;
   endproperty
   a_sdo_low: assert property (p_sdo_low)
      else $error("serial output not low during conversion");

   property p_float;
      cs_n [*4] |-> !sdo_oe;
   endproperty
   a_float: assert property (p_float)
      else $error("serial output driven while deselected");

   property p_first_bit;
      $rose(eoc) && !cs_n |-> sdo_oe;
   endproperty
   a_first_bit: assert property (p_first_bit)
      else $error("no output driven at end of conversion");

   property p_sclk_idle;
      cs_n || !eoc |-> !sclk;
   endproperty
   a_sclk_idle: assert property (p_sclk_idle)
      else $error("shift clock active while idle");

   property p_sclk_half;
      $rose(sclk) |-> sclk [*4] ##1 !sclk;
   endproperty
   a_sclk_half: assert property (p_sclk_half)
      else $error("shift clock high phase wrong");

   property p_sdi_edge;
      $changed(serial_input_byte) |-> !sclk;
   endproperty
   a_sdi_edge: assert property (p_sdi_edge)
      else $error("serial input changed while clock high");

   c_frame16: cover property ($fell(eoc) && n_rise == 5'h10);
   c_frame8: cover property ($fell(eoc) && n_rise == 5'h08);
   c_cs_up: cover property ($rose(cs_n));
endmodule : sah_sva

/* File: tb/sah_tb.sv */
// testbench joining host and converter ends over the link
// assumes one 200 MHz clock and word accesses on the bus
module sah_tb
   import sah_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [11:0] sample_code = 12'h000;
   logic [3:0] channel_sel;
   logic sample_hold;
   logic [31:0] rd;
   int failures = 0;
   int n_tests = 0;

   sah_link_if link ();

   sah_host sah_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .link(link.host));

   sah_device sah_device_i (.hclk(hclk), .hresetn(hresetn),
      .link(link.device), .sample_code(sample_code),
      .channel_sel(channel_sel), .sample_hold(sample_hold));

   sah_sva sah_sva_i (.hclk(hclk), .hresetn(hresetn), .cs_n(link.cs_n),
      .sclk(link.sclk), .serial_input_byte(link.serial_input_byte), .sdo(link.sdo),
      .sdo_oe(link.sdo_oe), .eoc(link.eoc));

   always #2.5 hclk = ~hclk;

   task check(input string nm, input logic [31:0] seen,
              input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= sah_htrans_nonseq;
      hsize <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task wait_stat(input int b, input logic v);
      int n;
      n = 0;
      do begin
         bus(1'b0, sah_reg_stat, 32'h0000_0000);
         n++;
      end while (rd[b] !== v && n < 1000);
      if (rd[b] !== v) failures++;
   endtask : wait_stat

   // one frame; nxt feeds the conversion that follows it
   task frame(input logic [7:0] c, input logic [11:0] nxt,
              input logic [15:0] m, input logic [15:0] e, input string nm);
      bus(1'b1, sah_reg_cmd, {24'h00_0000, c});
      wait_stat(0, 1'b1);
      wait_stat(0, 1'b0);
      sample_code <= nxt;
      bus(1'b0, sah_reg_res, 32'h0000_0000);
      check(nm, {16'h0000, rd[15:0] & m}, {16'h0000, e});
      check("hold", {31'h0, sample_hold}, 32'h0000_0000);
   endtask : frame

   task t_lengths;
      frame(8'h30, 12'hA5C, 16'h0FFF, 16'h0000, "first");
      check("chan3", {28'h0, channel_sel}, 32'h0000_0003);
      frame(8'h5C, 12'h3E1, 16'hFFFF, 16'hA5C0, "len16");
      check("chan5", {28'h0, channel_sel}, 32'h0000_0005);
   endtask : t_lengths

   task t_cs_toggle;
      wait_stat(2, 1'b1);
      bus(1'b1, sah_reg_cs, 32'h0000_0001);
      bus(1'b0, sah_reg_stat, 32'h0000_0000);
      check("cs_req", {31'h0, rd[1]}, 32'h0000_0001);
      repeat (40) @(posedge hclk);
      check("float", {31'h0, link.sdo_oe}, 32'h0000_0000);
      bus(1'b1, sah_reg_cs, 32'h0000_0000);
      repeat (40) @(posedge hclk);
      frame(8'h04, 12'h800, 16'h00FF, 16'h003E, "len8");
   endtask : t_cs_toggle

   task t_coding;
      frame(8'h01, 12'hFFF, 16'h0FFF, 16'h0800, "mid");
      frame(8'h02, 12'h003, 16'h0FFF, 16'h07FF, "signed");
   endtask : t_coding

   task t_order;
      frame(8'hF0, 12'h000, 16'h0FFF, 16'hC00, "lsb");
      bus(1'b0, sah_reg_cmd, 32'h0000_0000);
      check("cmd", rd, 32'h0000_00F0);
      frame(8'h00, 12'h000, 16'h0FFF, 16'h0000, "zero");
      bus(1'b0, 32'h0000_0010, 32'h0000_0000);
      check("unmapped", rd, 32'h0000_0000);
      check("hresp", {31'h0, hresp}, 32'h0000_0000);
   endtask : t_order

   task summarize;
      if (failures == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize

   initial begin
      #100000;
      failures++;
      summarize();
   end

   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b1, sah_reg_cs, 32'h0000_0000);
      t_lengths();
      t_cs_toggle();
      t_coding();
      t_order();
      summarize();
   end
endmodule : sah_tb
